/* File: acic_pkg.sv */
package acic_pkg;
  localparam int ACC_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] ACC_RST = 16'h0000;
  localparam logic [1:0] CC_RST = 2'h0;
  localparam logic ROL_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  typedef enum logic [2:0] {
    ACIC_NOP = 3'h0,
    ACIC_ONES = 3'h1,
    ACIC_TWOS = 3'h2,
    ACIC_INC = 3'h3,
    ACIC_DEC = 3'h4,
    ACIC_IDIS = 3'h5,
    ACIC_IENA = 3'h6
  } acic_op_t;
endpackage : acic_pkg

/* File: acic_if.sv */
`timescale 1ns/1ps
interface acic_irq_if;
  logic disable_pulse;
  logic enable_pulse;
  logic [1:0] req;
  logic [1:0] grant;
  logic masked;
  logic [1:0] pending;
  modport core (output disable_pulse, output enable_pulse, output req, input grant, input masked, input pending);
  modport mask (input disable_pulse, input enable_pulse, input req, output grant, output masked, output pending);
endinterface : acic_irq_if

/* File: acic_irq_mask.sv */
`timescale 1ns/1ps
module acic_irq_mask
  import acic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_ok,
  acic_irq_if.mask irq
);
  logic masked_q;
  logic [1:0] pend_q;
  logic [1:0] grant_q;
  wire logic [1:0] next_pend;
  wire logic [1:0] grant_sel;
  wire logic next_masked;
  // the disable strobe wins if both strobes collide
  assign next_masked = irq.disable_pulse ? 1'b1 : (irq.enable_pulse ? 1'b0 : masked_q);
  // one request at a time, process before time
  // a grant decided alongside the disable op would slip past the mask
  assign grant_sel = (masked_q || irq.disable_pulse || !ack_ok) ? 2'h0 :
                     (pend_q[0] ? 2'h1 : (pend_q[1] ? 2'h2 : 2'h0));
  // a new request wins over its own grant clear
  assign next_pend = (pend_q & ~grant_sel) | irq.req;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      masked_q <= MASK_RST;
      pend_q <= 2'h0;
      grant_q <= 2'h0;
    end
    else
    begin
      masked_q <= next_masked;
      pend_q <= next_pend;
      grant_q <= grant_sel;
    end
  end
  assign irq.masked = masked_q;
  assign irq.pending = pend_q;
  assign irq.grant = grant_q;

  property p_no_grant_masked;
    @(posedge clk) disable iff (rst) masked_q |=> grant_q == 2'h0;
  endproperty
  a_no_grant_masked: assert property (p_no_grant_masked) else $error("grant while masked");
  property p_req_kept;
    @(posedge clk) disable iff (rst) (masked_q && !irq.enable_pulse && irq.req[0]) |=> pend_q[0];
  endproperty
  a_req_kept: assert property (p_req_kept) else $error("masked request lost");
  property p_enable_clears;
    @(posedge clk) disable iff (rst) (irq.enable_pulse && !irq.disable_pulse) |=> !masked_q;
  endproperty
  a_enable_clears: assert property (p_enable_clears) else $error("enable did not clear mask");
  property p_disable_sets;
    @(posedge clk) disable iff (rst) irq.disable_pulse |=> masked_q;
  endproperty
  a_disable_sets: assert property (p_disable_sets) else $error("disable did not set mask");
  c_held_then_served: cover property (@(posedge clk) disable iff (rst) masked_q && pend_q != 2'h0 ##[1:20] grant_q != 2'h0);
endmodule : acic_irq_mask

/* File: acic_core.sv */
`timescale 1ns/1ps
module acic_core
  import acic_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic OP_VALID,
  input wire acic_pkg::acic_op_t OP_CODE,
  input wire logic [7:0] OP_IMM,
  input wire logic LOAD_VALID,
  input wire logic [15:0] LOAD_DATA,
  input wire logic ROL_SET_VALID,
  input wire logic ROL_SET_DATA,
  input wire logic PROC_IRQ,
  input wire logic TIME_IRQ,
  input wire logic IRQ_ACK_OK,
  output logic [15:0] ACCUMULATOR_ONE,
  output logic [1:0] COND_CODE,
  output logic RESULT_OF_LOGIC,
  output logic IRQ_MASKED,
  output logic [1:0] IRQ_PENDING,
  output logic PROC_IRQ_GRANT,
  output logic TIME_IRQ_GRANT
);
  import acic_pkg::*;
  acic_irq_if irq_bus ();
  logic [15:0] acc;
  logic [1:0] cc;
  logic rol;
  logic [1:0] proc_sync;
  logic [1:0] time_sync;
  logic [1:0] irq_q;
  wire logic do_ones;
  wire logic do_twos;
  wire logic do_inc;
  wire logic do_dec;
  wire logic [15:0] inv_acc;
  wire logic [15:0] neg_acc;
  wire logic [7:0] inc_lo;
  wire logic [7:0] dec_lo;
  wire logic [15:0] next_acc;
  wire logic [1:0] next_cc;
  wire logic [1:0] irq_edge;

  assign do_ones = OP_VALID && (OP_CODE == ACIC_ONES);
  assign do_twos = OP_VALID && (OP_CODE == ACIC_TWOS);
  assign do_inc = OP_VALID && (OP_CODE == ACIC_INC);
  assign do_dec = OP_VALID && (OP_CODE == ACIC_DEC);
  assign inv_acc = ~acc;
  assign neg_acc = inv_acc + ONE_WORD;
  // 8-bit sums drop the carry so the high byte never moves
  assign inc_lo = acc[7:0] + OP_IMM;
  assign dec_lo = acc[7:0] - OP_IMM;
  assign next_acc = do_ones ? inv_acc :
                    do_twos ? neg_acc :
                    do_inc ? {acc[15:8], inc_lo} :
                    do_dec ? {acc[15:8], dec_lo} :
                    LOAD_VALID ? LOAD_DATA : acc;
  // cc: 2'h0 zero, 2'h1 negative, 2'h2 positive
  assign next_cc = !do_twos ? cc :
                   (neg_acc == 16'h0000) ? 2'h0 : (neg_acc[15] ? 2'h1 : 2'h2);
  // rol only follows the logic unit, never these ops
  assign irq_edge = {time_sync[1], proc_sync[1]};

  assign irq_bus.disable_pulse = OP_VALID && (OP_CODE == ACIC_IDIS);
  assign irq_bus.enable_pulse = OP_VALID && (OP_CODE == ACIC_IENA);
  assign irq_bus.req = irq_edge & ~irq_q;

  acic_irq_mask u_mask (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ack_ok(IRQ_ACK_OK),
    .irq(irq_bus.mask)
  );

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      acc <= ACC_RST;
      cc <= CC_RST;
      rol <= ROL_RST;
      proc_sync <= 2'h0;
      time_sync <= 2'h0;
      irq_q <= 2'h0;
    end
    else
    begin
      acc <= next_acc;
      cc <= next_cc;
      rol <= ROL_SET_VALID ? ROL_SET_DATA : rol;
      proc_sync <= {proc_sync[0], PROC_IRQ};
      time_sync <= {time_sync[0], TIME_IRQ};
      irq_q <= irq_edge;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ACCUMULATOR_ONE <= ACC_RST;
      COND_CODE <= CC_RST;
      RESULT_OF_LOGIC <= ROL_RST;
      IRQ_MASKED <= MASK_RST;
      IRQ_PENDING <= 2'h0;
      PROC_IRQ_GRANT <= 1'b0;
      TIME_IRQ_GRANT <= 1'b0;
    end
    else
    begin
      ACCUMULATOR_ONE <= next_acc;
      COND_CODE <= next_cc;
      RESULT_OF_LOGIC <= ROL_SET_VALID ? ROL_SET_DATA : rol;
      IRQ_MASKED <= irq_bus.masked;
      IRQ_PENDING <= irq_bus.pending;
      PROC_IRQ_GRANT <= irq_bus.grant[0];
      TIME_IRQ_GRANT <= irq_bus.grant[1];
    end
  end

  property p_ones_inv;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_ones |=> ACCUMULATOR_ONE == ~$past(acc);
  endproperty
  a_ones_inv: assert property (p_ones_inv) else $error("ones complement wrong");
  property p_ones_cc;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_ones |=> COND_CODE == $past(cc);
  endproperty
  a_ones_cc: assert property (p_ones_cc) else $error("ones complement touched codes");
  property p_twos_neg;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_twos |=> (ACCUMULATOR_ONE + $past(acc)) == 16'h0000;
  endproperty
  a_twos_neg: assert property (p_twos_neg) else $error("twos complement wrong");
  property p_twos_cc;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_twos |=> COND_CODE == ((ACCUMULATOR_ONE == 16'h0000) ? 2'h0 :
      (ACCUMULATOR_ONE[15] ? 2'h1 : 2'h2));
  endproperty
  a_twos_cc: assert property (p_twos_cc) else $error("twos complement codes wrong");
  property p_conv_rol;
    @(posedge CLK_SYS) disable iff (SYS_RST) ((do_ones || do_twos) && !ROL_SET_VALID) |=> RESULT_OF_LOGIC == $past(rol);
  endproperty
  a_conv_rol: assert property (p_conv_rol) else $error("conversion changed logic bit");
  property p_inc_low;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_inc |=>
      ACCUMULATOR_ONE == {$past(acc[15:8]), 8'(($past(acc[7:0]) + $past(OP_IMM)))};
  endproperty
  a_inc_low: assert property (p_inc_low) else $error("increment wrong");
  property p_dec_low;
    @(posedge CLK_SYS) disable iff (SYS_RST) do_dec |=>
      ACCUMULATOR_ONE == {$past(acc[15:8]), 8'(($past(acc[7:0]) - $past(OP_IMM)))};
  endproperty
  a_dec_low: assert property (p_dec_low) else $error("decrement wrong");
  property p_incdec_keep;
    @(posedge CLK_SYS) disable iff (SYS_RST) ((do_inc || do_dec) && !ROL_SET_VALID) |=>
      (COND_CODE == $past(cc)) && (RESULT_OF_LOGIC == $past(rol));
  endproperty
  a_incdec_keep: assert property (p_incdec_keep) else $error("inc or dec changed state");
  property p_mask_keep;
    @(posedge CLK_SYS) disable iff (SYS_RST) ((irq_bus.disable_pulse || irq_bus.enable_pulse) && !ROL_SET_VALID) |=>
      (COND_CODE == $past(cc)) && (RESULT_OF_LOGIC == $past(rol));
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask op changed state");
  property p_masked_out;
    @(posedge CLK_SYS) disable iff (SYS_RST) IRQ_MASKED |-> !PROC_IRQ_GRANT && !TIME_IRQ_GRANT ##1 1'b1;
  endproperty
  a_masked_out: assert property (p_masked_out) else $error("grant while masked output");
  property p_load_acc;
    @(posedge CLK_SYS) disable iff (SYS_RST) (LOAD_VALID && !(do_ones || do_twos || do_inc || do_dec)) |=>
      ACCUMULATOR_ONE == $past(LOAD_DATA);
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("load did not land");
  property p_idle_acc;
    @(posedge CLK_SYS) disable iff (SYS_RST) (!LOAD_VALID && !(do_ones || do_twos || do_inc || do_dec)) |=>
      ACCUMULATOR_ONE == $past(acc);
  endproperty
  a_idle_acc: assert property (p_idle_acc) else $error("accumulator moved without an op");
  property p_cc_only_twos;
    @(posedge CLK_SYS) disable iff (SYS_RST) !do_twos |=> COND_CODE == $past(cc);
  endproperty
  a_cc_only_twos: assert property (p_cc_only_twos) else $error("codes moved without twos op");
  property p_rol_keep;
    @(posedge CLK_SYS) disable iff (SYS_RST) !ROL_SET_VALID |=> RESULT_OF_LOGIC == $past(rol);
  endproperty
  a_rol_keep: assert property (p_rol_keep) else $error("logic bit moved without a write");
  property p_incdec_high;
    @(posedge CLK_SYS) disable iff (SYS_RST) (do_inc || do_dec) |=> ACCUMULATOR_ONE[15:8] == $past(acc[15:8]);
  endproperty
  a_incdec_high: assert property (p_incdec_high) else $error("high byte moved on inc or dec");
  property p_disable_out;
    @(posedge CLK_SYS) disable iff (SYS_RST) irq_bus.disable_pulse |=> ##1 IRQ_MASKED;
  endproperty
  a_disable_out: assert property (p_disable_out) else $error("mask output not set");
  property p_enable_unmask;
    @(posedge CLK_SYS) disable iff (SYS_RST) (irq_bus.enable_pulse && !irq_bus.disable_pulse) |=> ##1 !IRQ_MASKED;
  endproperty
  a_enable_unmask: assert property (p_enable_unmask) else $error("mask output not cleared");
  property p_disable_blocks;
    @(posedge CLK_SYS) disable iff (SYS_RST) irq_bus.disable_pulse |=> ##1 (!PROC_IRQ_GRANT && !TIME_IRQ_GRANT);
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("grant after disable op");
  property p_proc_served;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (irq_bus.pending[0] && !irq_bus.masked && !irq_bus.disable_pulse && IRQ_ACK_OK) |=> ##1 PROC_IRQ_GRANT;
  endproperty
  a_proc_served: assert property (p_proc_served) else $error("pending process request not served");
  property p_time_served;
    @(posedge CLK_SYS) disable iff (SYS_RST) (irq_bus.pending[1] && !irq_bus.pending[0] && !irq_bus.masked &&
      !irq_bus.disable_pulse && IRQ_ACK_OK) |=> ##1 TIME_IRQ_GRANT;
  endproperty
  a_time_served: assert property (p_time_served) else $error("pending time request not served");
  property p_no_ack;
    @(posedge CLK_SYS) disable iff (SYS_RST) !IRQ_ACK_OK |=> ##1 (!PROC_IRQ_GRANT && !TIME_IRQ_GRANT);
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("grant without ack");
  property p_grant_one;
    @(posedge CLK_SYS) disable iff (SYS_RST) !(PROC_IRQ_GRANT && TIME_IRQ_GRANT);
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("two grants at once");

  c_twos: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) do_twos);
  c_dec_wrap: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) do_dec && OP_IMM > acc[7:0]);
  c_mask_cycle: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) irq_bus.disable_pulse ##[1:20] irq_bus.enable_pulse);
  c_load_refused: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) LOAD_VALID && (do_inc || do_dec));
endmodule : acic_core

/* File: acic_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  import acic_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, load_valid = 1'b0;
  logic rol_set_valid = 1'b0, rol_set_data = 1'b0, proc_irq = 1'b0, time_irq = 1'b0, irq_ack_ok = 1'b1;
  acic_op_t op_code = ACIC_NOP;
  logic [7:0] op_imm = 8'h00;
  logic [15:0] load_data = 16'h0000;
  wire logic [15:0] acc;
  wire logic [1:0] cc, pend;
  wire logic rol, masked, pg, tg;
  int miscompares = 0, checks_done = 0, cycles = 0, pgs = 0, tgs = 0;
  // model state kept as plain integers
  int m_acc = 0, m_cc = 0, m_rol = 0;
  // expected grant sources in order: 0 process, 1 time
  int exp_grant[$];
  int exp_id = 0, got_id = 0;
  acic_core uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_IMM(op_imm),
    .LOAD_VALID(load_valid), .LOAD_DATA(load_data), .ROL_SET_VALID(rol_set_valid), .ROL_SET_DATA(rol_set_data),
    .PROC_IRQ(proc_irq), .TIME_IRQ(time_irq), .IRQ_ACK_OK(irq_ack_ok), .ACCUMULATOR_ONE(acc), .COND_CODE(cc),
    .RESULT_OF_LOGIC(rol), .IRQ_MASKED(masked), .IRQ_PENDING(pend), .PROC_IRQ_GRANT(pg), .TIME_IRQ_GRANT(tg));
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // a run needs well under 2000 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task check_state;
    `CHK("accumulator", 16'(m_acc), acc)
    `CHK("cond_code", 2'(m_cc), cc)
    `CHK("result_of_logic", 1'(m_rol), rol)
  endtask : check_state
  // do_op raises load at random in ONES to DEC op cycles: the op must win
  task do_ld(input logic [15:0] d);
    op_valid = 1'b0;
    load_valid = 1'b1;
    load_data = d;
    m_acc = d;
    @(negedge clk_sys);
    check_state();
  endtask : do_ld
  task do_op(input acic_op_t c, input logic [7:0] imm);
    op_valid = 1'b1;
    op_code = c;
    op_imm = imm;
    load_valid = (c >= ACIC_ONES && c <= ACIC_DEC) ? 1'($urandom) : 1'b0;
    load_data = 16'($urandom);
    rol_set_valid = 1'b0;
    case (c)
      ACIC_ONES: m_acc = ~m_acc & 'hffff;
      ACIC_TWOS: m_acc = (~m_acc + 1) & 'hffff;
      ACIC_INC: m_acc = (m_acc & 'hff00) | ((m_acc + imm) & 'hff);
      ACIC_DEC: m_acc = (m_acc & 'hff00) | ((m_acc - imm) & 'hff);
      default: ;
    endcase
    if (c == ACIC_TWOS)
      m_cc = (m_acc == 0) ? 0 : (m_acc >= 'h8000) ? 1 : 2;
    @(negedge clk_sys);
    check_state();
  endtask : do_op
  task wait_grants(input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      if (tg === 1'b1)
        `CHK("grant order", 1, int'(pgs > 0))
      if (pg === 1'b1 || tg === 1'b1)
      begin
        got_id = (tg === 1'b1) ? 1 : 0;
        exp_id = (exp_grant.size() > 0) ? exp_grant.pop_front() : -1;
        `CHK("grant source", exp_id, got_id)
      end
      pgs += int'(pg === 1'b1);
      tgs += int'(tg === 1'b1);
    end
  endtask : wait_grants
  initial
  begin
    void'($urandom(20));
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    check_state();
    rol_set_valid = 1'b1;
    rol_set_data = 1'b1;
    m_rol = 1;
    @(negedge clk_sys);
    check_state();
    do_ld(16'h1010);
    do_op(ACIC_INC, 8'd16);
    do_op(ACIC_DEC, 8'd33);
    `CHK("dec result", 16'h10ff, acc)
    do_ld(16'hffff);
    do_op(ACIC_INC, 8'hff);
    do_ld(16'h0000);
    do_op(ACIC_TWOS, 8'h00);
    do_ld(16'h8000);
    do_op(ACIC_TWOS, 8'h00);
    do_op(ACIC_ONES, 8'h00);
    do_ld(16'hfff0);
    do_op(ACIC_TWOS, 8'h00);
    do_op(ACIC_NOP, 8'h12);
    // random mix of all codes, loads and immediates
    repeat (400)
    begin
      if ($urandom % 4 == 0)
        do_ld(16'($urandom));
      else
        do_op(acic_op_t'(3'($urandom % 7)), 8'($urandom));
    end
    do_op(ACIC_IENA, 8'h00);
    op_valid = 1'b0;
    proc_irq = 1'b1;
    exp_grant.push_back(0);
    wait_grants(12);
    `CHK("unmasked grant", 1, pgs)
    proc_irq = 1'b0;
    do_op(ACIC_IDIS, 8'h00);
    op_valid = 1'b0;
    wait_grants(2);
    `CHK("mask", 1'b1, masked)
    pgs = 0;
    proc_irq = 1'b1;
    time_irq = 1'b1;
    wait_grants(12);
    `CHK("masked grants", 0, pgs + tgs)
    `CHK("pending", 2'h3, pend)
    exp_grant.push_back(0);
    exp_grant.push_back(1);
    do_op(ACIC_IENA, 8'h00);
    op_valid = 1'b0;
    wait_grants(15);
    `CHK("proc grants", 1, pgs)
    `CHK("time grants", 1, tgs)
    `CHK("mask", 1'b0, masked)
    // a request with the core unable to take it waits in pending
    proc_irq = 1'b0;
    wait_grants(3);
    irq_ack_ok = 1'b0;
    proc_irq = 1'b1;
    wait_grants(10);
    `CHK("grant without ack", 1, pgs)
    `CHK("pending held", 2'h1, pend)
    irq_ack_ok = 1'b1;
    exp_grant.push_back(0);
    wait_grants(8);
    `CHK("grant after ack", 2, pgs)
    `CHK("grants left", 0, exp_grant.size())
    check_state();
    print_verdict();
  end
endmodule : testbench
